// ### cpu_ctrl_pkg.sv
// constants, encodings and carriers for the cpu control register block
// assumes a 16-bit address map and byte-wide data memory
package cpu_ctrl_pkg;
    // fixed address areas
    localparam logic [15:0] RESET_VEC_LO = 16'h0000;
    localparam logic [15:0] RESET_VEC_HI = 16'h0001;
    localparam logic [15:0] DBG_ID_LO = 16'h0085;
    localparam logic [15:0] DBG_ID_HI = 16'h008E;
    localparam logic [15:0] DBG_ID2_LO = 16'h1085;
    localparam logic [15:0] DBG_ID2_HI = 16'h108E;
    localparam logic [15:0] FAR_LO = 16'h0800;
    localparam logic [15:0] FAR_HI = 16'h0FFF;
    localparam logic [15:0] RAM_BASE_384 = 16'hFD80;
    localparam logic [15:0] RAM_BASE_512 = 16'hFD00;
    localparam logic [15:0] RAM_BASE_768 = 16'hFC00;
    localparam logic [15:0] RAM_END = 16'hFEFF;
    localparam logic [15:0] BANK_LO = 16'hFEE0;
    localparam logic [15:0] BANK_TOP = 16'hFEF8;
    localparam logic [15:0] SFR_LO = 16'hFF00;
    localparam logic [15:0] SFR_HI = 16'hFFFF;
    localparam int RAM_384 = 384;
    localparam int RAM_512 = 512;
    localparam int RAM_768 = 768;
    localparam logic [15:0] BANK_STRIDE = 16'h0008;
    // status word layout and reset value
    localparam int PSW_CY = 0;
    localparam int PSW_ISP = 1;
    localparam int PSW_BANK_SELECT_LOW = 3;
    localparam int PSW_AC = 4;
    localparam int PSW_BANK_SELECT_HIGH = 5;
    localparam int PSW_Z = 6;
    localparam int PSW_IE = 7;
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // register bus map
    localparam logic [3:0] OFS_PC = 4'h0;
    localparam logic [3:0] OFS_PSW = 4'h4;
    localparam logic [3:0] OFS_SP = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // core commands
    typedef enum logic [3:0] {
        OP_NOP, OP_ADVANCE, OP_BRANCH, OP_CALL, OP_FAR_CALL, OP_INT_ACK,
        OP_BRK, OP_RET, OP_INTERRUPT_RETURN_OP, OP_BREAK_RETURN_OP, OP_PUSH_PSW, OP_POP_PSW,
        OP_DI, OP_EI, OP_SEL_BANK
    } cmd_e;
    typedef enum logic [2:0] {
        RG_ROM, RG_DBG_ID, RG_RAM, RG_BANK, RG_SFR, RG_NONE
    } region_e;
    typedef struct packed {
        logic valid;
        cmd_e op;
        logic [15:0] target;
        logic [2:0] len;
        logic [1:0] bank;
    } cmd_s;
    typedef struct packed {
        logic alu_we;
        logic sub;
        logic [7:0] a;
        logic [7:0] b;
        logic cy_we;
        logic cy_val;
    } alu_s;
    typedef struct packed {
        logic we;
        logic pair;
        logic [2:0] idx;
        logic [15:0] wdata;
    } reg_acc_s;
    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dat_acc_s;
endpackage

// ### cpu_ctrl_regs.sv
// program counter, status word, stack pointer, register banks and ram
// assumes one core drives cmd, alu, reg and data ports in its own clock
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module cpu_ctrl_regs import cpu_ctrl_pkg::*; #(
    parameter int RAM_BYTES = RAM_768
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [15:0] prog_addr_o,
    input wire logic [7:0] prog_data_i,
    input wire cmd_s cmd_i,
    output logic cmd_ready_o,
    output logic cmd_err_o,
    input wire alu_s alu_i,
    input wire reg_acc_s reg_i,
    output logic [15:0] reg_rdata_o,
    input wire dat_acc_s dat_i,
    output logic [7:0] dat_rdata_o,
    output region_e dat_region_o,
    output logic fetch_fault_o,
    input wire logic irq_req_i,
    input wire logic irq_high_i,
    output logic irq_take_o,
    output logic [15:0] pc_o,
    output logic [7:0] psw_o,
    output logic stack_fault_o
);
    localparam logic [15:0] RAM_BASE = (RAM_BYTES == RAM_384) ? RAM_BASE_384 :
        (RAM_BYTES == RAM_512) ? RAM_BASE_512 : RAM_BASE_768;
    localparam int IW = $clog2(RAM_BYTES);

    typedef enum logic [2:0] {
        ST_BOOT_LO, ST_BOOT_HI, ST_BOOT_LD, ST_RUN, ST_PUSH, ST_POP
    } st_e;

    // address decoding helpers
    function automatic logic in_ram(input logic [15:0] a);
        in_ram = (a >= RAM_BASE) && (a <= RAM_END);
    endfunction
    function automatic logic in_bank(input logic [15:0] a);
        in_bank = (a >= BANK_LO) && (a <= RAM_END);
    endfunction
    function automatic region_e region_of(input logic [15:0] a);
        if (a >= SFR_LO) region_of = RG_SFR;
        else if (in_bank(a)) region_of = RG_BANK;
        else if (in_ram(a)) region_of = RG_RAM;
        else if ((a >= DBG_ID_LO && a <= DBG_ID_HI) ||
                 (a >= DBG_ID2_LO && a <= DBG_ID2_HI)) region_of = RG_DBG_ID;
        else if (a < RAM_BASE_768) region_of = RG_ROM;
        else region_of = RG_NONE;
    endfunction
    function automatic logic [IW-1:0] ram_idx(input logic [15:0] a);
        logic [15:0] d;
        d = a - RAM_BASE;
        ram_idx = d[IW-1:0];
    endfunction
    // bank n sits below bank n-1, register r at base plus r
    function automatic logic [15:0] bank_addr(input logic [1:0] bk,
                                              input logic [2:0] r);
        bank_addr = BANK_TOP - BANK_STRIDE * {14'h0000, bk} + {13'h0000, r};
    endfunction
    function automatic logic [15:0] strb16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        strb16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [7:0] mem [0:RAM_BYTES-1];
    st_e st_r, st_nxt;
    logic [15:0] pc_r, sp_r, awaddr_pad;
    logic [7:0] psw_r, vec_lo_r;
    logic [23:0] stk_r, stk_nxt;
    logic [1:0] cnt_r;
    cmd_e kind_r;
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r, awready_r, wready_r;
    logic arready_r, stack_fault_r;
    logic [3:0] awaddr_r, wstrb_r;
    logic [31:0] wdata_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    logic bus_wr, take_cmd, far_bad;
    logic [1:0] bank_sel;
    logic [15:0] push_addr, ret_addr;
    logic [8:0] sum9;
    logic [4:0] sum5;

    assign bank_sel = {psw_r[PSW_BANK_SELECT_HIGH], psw_r[PSW_BANK_SELECT_LOW]};
    assign bus_wr = aw_full_r && w_full_r && !bvalid_r;
    assign take_cmd = cmd_i.valid && st_r == ST_RUN;
    assign far_bad = cmd_i.op == OP_FAR_CALL &&
        (cmd_i.target < FAR_LO || cmd_i.target > FAR_HI);
    assign push_addr = sp_r - 16'h0001;
    assign ret_addr = pc_r + {13'h0000, cmd_i.len};
    assign awaddr_pad = {12'h000, awaddr_r};

    // sequencer state: boot vector fetch, run, stack byte moves
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_BOOT_LO: st_nxt = ST_BOOT_HI;
            ST_BOOT_HI: st_nxt = ST_BOOT_LD;
            ST_BOOT_LD: st_nxt = ST_RUN;
            ST_RUN: begin
                if (take_cmd && !far_bad) begin
                    case (cmd_i.op)
                        OP_CALL, OP_FAR_CALL, OP_INT_ACK, OP_BRK,
                        OP_PUSH_PSW: st_nxt = ST_PUSH;
                        OP_RET, OP_INTERRUPT_RETURN_OP, OP_BREAK_RETURN_OP, OP_POP_PSW: st_nxt = ST_POP;
                        default: st_nxt = ST_RUN;
                    endcase
                end
            end
            ST_PUSH, ST_POP: if (cnt_r == 2'd1) st_nxt = ST_RUN;
            default: st_nxt = ST_RUN;
        endcase
    end

    // popped bytes shift in from the top: first byte ends lowest
    always_comb begin
        stk_nxt = {mem[ram_idx(sp_r)], stk_r[23:8]};
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= ST_BOOT_LO;
            cmd_ready_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cmd_ready_o <= st_nxt == ST_RUN;
        end
    end

    // stack byte queue and count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stk_r <= 24'h000000;
            cnt_r <= 2'd0;
            kind_r <= OP_NOP;
        end else if (take_cmd && !far_bad) begin
            kind_r <= cmd_i.op;
            case (cmd_i.op)
                OP_INT_ACK, OP_BRK: begin
                    stk_r <= {psw_r, ret_addr};
                    cnt_r <= 2'd3;
                end
                OP_CALL, OP_FAR_CALL: begin
                    stk_r <= {ret_addr, 8'h00};
                    cnt_r <= 2'd2;
                end
                OP_PUSH_PSW: begin
                    stk_r <= {psw_r, 16'h0000};
                    cnt_r <= 2'd1;
                end
                OP_INTERRUPT_RETURN_OP, OP_BREAK_RETURN_OP: cnt_r <= 2'd3;
                OP_RET: cnt_r <= 2'd2;
                OP_POP_PSW: cnt_r <= 2'd1;
                default: cnt_r <= 2'd0;
            endcase
        end else if (st_r == ST_PUSH) begin
            stk_r <= {stk_r[15:0], 8'h00};
            cnt_r <= cnt_r - 2'd1;
        end else if (st_r == ST_POP) begin
            stk_r <= stk_nxt;
            cnt_r <= cnt_r - 2'd1;
        end
    end

    // stack pointer: stack moves, then bus loads
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_r <= SP_RESET;
        end else if (st_r == ST_PUSH) begin
            sp_r <= push_addr;
        end else if (st_r == ST_POP) begin
            sp_r <= sp_r + 16'h0001;
        end else if (bus_wr && awaddr_r == OFS_SP) begin
            sp_r <= strb16(sp_r, wdata_r, wstrb_r);
        end
    end

    // stack outside ram is caught; a fresh pointer load clears it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stack_fault_r <= 1'b0;
        end else if ((st_r == ST_PUSH && !in_ram(push_addr)) ||
                     (st_r == ST_POP && !in_ram(sp_r))) begin
            stack_fault_r <= 1'b1;
        end else if (bus_wr && awaddr_r == OFS_SP) begin
            stack_fault_r <= 1'b0;
        end
    end

    // program counter: boot vector, pops, core, bus
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_r <= PC_RESET;
            vec_lo_r <= 8'h00;
        end else if (st_r == ST_BOOT_HI) begin
            vec_lo_r <= prog_data_i;
        end else if (st_r == ST_BOOT_LD) begin
            pc_r <= {prog_data_i, vec_lo_r};
        end else if (st_r == ST_POP && cnt_r == 2'd1 &&
                     kind_r != OP_POP_PSW) begin
            pc_r <= kind_r == OP_RET ? stk_nxt[23:8] : stk_nxt[15:0];
        end else if (take_cmd && !far_bad) begin
            case (cmd_i.op)
                OP_ADVANCE: pc_r <= ret_addr;
                OP_BRANCH, OP_CALL, OP_FAR_CALL, OP_INT_ACK,
                OP_BRK: pc_r <= cmd_i.target;
                default: pc_r <= pc_r;
            endcase
        end else if (bus_wr && awaddr_r == OFS_PC) begin
            pc_r <= strb16(pc_r, wdata_r, wstrb_r);
        end
    end

    assign sum9 = alu_i.sub ? {1'b0, alu_i.a} - {1'b0, alu_i.b}
                            : {1'b0, alu_i.a} + {1'b0, alu_i.b};
    assign sum5 = alu_i.sub ? {1'b0, alu_i.a[3:0]} - {1'b0, alu_i.b[3:0]}
                            : {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]};

    // status word: restores, flag ops, alu results, bus
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            psw_r <= PSW_RESET;
        end else if (st_r == ST_POP && cnt_r == 2'd1 &&
                     (kind_r == OP_POP_PSW || kind_r == OP_INTERRUPT_RETURN_OP ||
                      kind_r == OP_BREAK_RETURN_OP)) begin
            psw_r <= stk_nxt[23:16];
        end else if (take_cmd && cmd_i.op == OP_DI) begin
            psw_r[PSW_IE] <= 1'b0;
        end else if (take_cmd && cmd_i.op == OP_INT_ACK) begin
            psw_r[PSW_IE] <= 1'b0;
        end else if (take_cmd && cmd_i.op == OP_EI) begin
            psw_r[PSW_IE] <= 1'b1;
        end else if (take_cmd && cmd_i.op == OP_SEL_BANK) begin
            psw_r[PSW_BANK_SELECT_HIGH] <= cmd_i.bank[1];
            psw_r[PSW_BANK_SELECT_LOW] <= cmd_i.bank[0];
        end else if (alu_i.alu_we) begin
            psw_r[PSW_Z] <= sum9[7:0] == 8'h00;
            psw_r[PSW_AC] <= sum5[4];
            psw_r[PSW_CY] <= sum9[8];
        end else if (alu_i.cy_we) begin
            psw_r[PSW_CY] <= alu_i.cy_val;
        end else if (bus_wr && awaddr_r == OFS_PSW && wstrb_r[0]) begin
            psw_r <= wdata_r[7:0];
        end
    end

    // far call outside its window is refused and reported
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) cmd_err_o <= 1'b0;
        else cmd_err_o <= take_cmd && far_bad;
    end

    // shared byte store: stack, bank registers and data port
    always_ff @(posedge clk_i) begin
        if (dat_i.valid && dat_i.we && in_ram(dat_i.addr))
            mem[ram_idx(dat_i.addr)] <= dat_i.wdata;
        if (reg_i.we && reg_i.pair) begin
            mem[ram_idx(bank_addr(bank_sel, {reg_i.idx[1:0], 1'b0}))]
                <= reg_i.wdata[7:0];
            mem[ram_idx(bank_addr(bank_sel, {reg_i.idx[1:0], 1'b1}))]
                <= reg_i.wdata[15:8];
        end else if (reg_i.we)
            mem[ram_idx(bank_addr(bank_sel, reg_i.idx))]
                <= reg_i.wdata[7:0];
        if (st_r == ST_PUSH && in_ram(push_addr))
            mem[ram_idx(push_addr)] <= stk_r[23:16];
    end

    // read ports, fetch check and interrupt gate, all registered
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 16'h0000;
            dat_rdata_o <= 8'h00;
            dat_region_o <= RG_ROM;
            fetch_fault_o <= 1'b0;
            irq_take_o <= 1'b0;
            prog_addr_o <= RESET_VEC_LO;
        end else begin
            if (reg_i.pair)
                reg_rdata_o <= {
                    mem[ram_idx(bank_addr(bank_sel, {reg_i.idx[1:0], 1'b1}))],
                    mem[ram_idx(bank_addr(bank_sel, {reg_i.idx[1:0], 1'b0}))]};
            else
                reg_rdata_o <= {8'h00,
                    mem[ram_idx(bank_addr(bank_sel, reg_i.idx))]};
            dat_rdata_o <= in_ram(dat_i.addr) ? mem[ram_idx(dat_i.addr)]
                                               : 8'h00;
            dat_region_o <= region_of(dat_i.addr);
            fetch_fault_o <= in_bank(pc_r);
            irq_take_o <= irq_req_i && psw_r[PSW_IE] &&
                          (irq_high_i || psw_r[PSW_ISP]);
            prog_addr_o <= st_nxt == ST_BOOT_HI ? RESET_VEC_HI : pc_r;
        end
    end

    // register bus write side: address and data taken in either order
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && awready_r) begin
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_r) begin
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (bus_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (awaddr_pad[3:0] == OFS_STAT) ? RESP_SLVERR
                                                         : RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // register bus read side
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid_i && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr_i)
                OFS_PC: rdata_r <= {16'h0000, pc_r};
                OFS_PSW: rdata_r <= {24'h000000, psw_r};
                OFS_SP: rdata_r <= {16'h0000, sp_r};
                OFS_STAT: rdata_r <= {29'h00000000, stack_fault_r,
                                      st_r == ST_RUN, st_r == ST_POP};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign pc_o = pc_r;
    assign psw_o = psw_r;
    assign stack_fault_o = stack_fault_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence int_taken;
        take_cmd && (cmd_i.op == OP_INT_ACK || cmd_i.op == OP_BRK);
    endsequence
    sequence three_pushes;
        (st_r == ST_PUSH) [*3] ##1 (st_r == ST_RUN);
    endsequence
    a_psw_reset_val: assert property (st_r == ST_BOOT_LO |->
        psw_r == PSW_RESET) else $error("status word not 02 at boot");
    a_vector_load: assert property (st_r == ST_BOOT_LD |=>
        pc_r == {$past(prog_data_i), vec_lo_r})
        else $error("reset vector not loaded");
    a_int_push_three: assert property (int_taken |=> three_pushes)
        else $error("interrupt push not three bytes");
    a_push_predec: assert property (st_r == ST_PUSH |=>
        sp_r == $past(sp_r) - 16'h0001) else $error("push no decrement");
    a_pop_postinc: assert property (st_r == ST_POP |=>
        sp_r == $past(sp_r) + 16'h0001) else $error("pop no increment");
    a_irq_gate_en: assert property (irq_take_o |->
        $past(psw_r[PSW_IE]) && ($past(irq_high_i) || $past(psw_r[PSW_ISP])))
        else $error("interrupt taken while blocked");
    a_di_clears_ie: assert property (take_cmd && cmd_i.op == OP_DI |=>
        !psw_r[PSW_IE]) else $error("disable op left enable set");
    a_zero_flag: assert property (st_r == ST_RUN && !cmd_i.valid &&
        alu_i.alu_we |=> psw_r[PSW_Z] == ($past(sum9[7:0]) == 8'h00))
        else $error("zero flag wrong");
    a_fetch_fault: assert property (##1 fetch_fault_o == in_bank($past(pc_r)))
        else $error("bank area fetch not flagged");
    a_far_refuse: assert property (take_cmd && far_bad |=>
        cmd_err_o && st_r == ST_RUN) else $error("far call outside window");
endmodule

// ### cpu_ctrl_tb.sv
// self-checking bench for the cpu control register block
// assumes a one-cycle program rom holding the boot vector 1234
`timescale 1ns/100ps
module testbench;
import cpu_ctrl_pkg::*;
logic clk_i, rstn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
logic s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i;
logic s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, cmd_ready_o;
logic cmd_err_o, fetch_fault_o, irq_req_i, irq_high_i, irq_take_o;
logic stack_fault_o, got_err;
logic [3:0] s_axi_awaddr_i, s_axi_wstrb_i, s_axi_araddr_i;
logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
logic [15:0] prog_addr_o, reg_rdata_o, pc_o;
logic [7:0] prog_data_i, dat_rdata_o, psw_o;
cmd_s cmd_i;
alu_s alu_i;
reg_acc_s reg_i;
dat_acc_s dat_i;
region_e dat_region_o;
int failures, samples_checked;
cpu_ctrl_regs u_dut (.clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .prog_addr_o,
    .prog_data_i, .cmd_i, .cmd_ready_o, .cmd_err_o, .alu_i, .reg_i,
    .reg_rdata_o, .dat_i, .dat_rdata_o, .dat_region_o, .fetch_fault_o,
    .irq_req_i, .irq_high_i, .irq_take_o, .pc_o, .psw_o, .stack_fault_o);
// rom: vector high byte 12 at address 0001, low byte 34 at every other address
always @(posedge clk_i)
    prog_data_i <= (prog_addr_o == 16'h0001) ? 8'h12 : 8'h34;
initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
end
task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
        failures++;
        $display("mismatch %s expected %h seen %h", n, e, g);
    end
endtask
task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do begin
        @(posedge clk_i);
        if (s_axi_awready_o) s_axi_awvalid_i <= 0;
        if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 0;
    chk("bresp", er, s_axi_bresp_o);
    @(posedge clk_i);
endtask
task automatic rd(logic [3:0] a, logic [31:0] e, logic [1:0] er);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do begin
        @(posedge clk_i);
        if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 0;
    chk("rdata", e, s_axi_rdata_o);
    chk("rresp", er, s_axi_rresp_o);
    @(posedge clk_i);
endtask
task automatic op(cmd_e o, logic [15:0] t, logic [2:0] l);
    while (!cmd_ready_o) @(posedge clk_i);
    cmd_i <= '{1'b1, o, t, l, t[1:0]};
    @(posedge clk_i);
    cmd_i.valid <= 0;
    @(posedge clk_i);
    got_err = cmd_err_o;
    do @(posedge clk_i); while (!cmd_ready_o);
    @(posedge clk_i);
endtask
task automatic mem(logic [15:0] a, logic [7:0] e, region_e g);
    dat_i <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_i);
    dat_i.valid <= 0;
    @(posedge clk_i);
    chk("mem", e, dat_rdata_o);
    chk("region", g, dat_region_o);
endtask
task automatic give_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// reset release, boot vector and bus error answers
task automatic t_boot;
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= '0;
    {s_axi_arvalid_i, s_axi_rready_i, irq_req_i, irq_high_i} <= '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= '0;
    {cmd_i, alu_i, reg_i, dat_i} <= '0;
    s_axi_wstrb_i <= 4'h3;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1;
    repeat (6) @(posedge clk_i);
    rd(OFS_PSW, 32'h02, RESP_OKAY);
    rd(OFS_PC, 32'h1234, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(OFS_STAT, 32'h0, RESP_SLVERR);
endtask
// interrupt gate against enable and priority
task automatic t_irq;
    irq_req_i <= 1;
    repeat (2) @(posedge clk_i);
    chk("take", 0, irq_take_o);
    op(OP_EI, 0, 0);
    chk("take", 1, irq_take_o);
    wr(OFS_PSW, 32'h80, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    chk("take", 0, irq_take_o);
    irq_high_i <= 1;
    repeat (2) @(posedge clk_i);
    chk("take", 1, irq_take_o);
endtask
// interrupt frame, far call window and plain return
task automatic t_int_stack;
    wr(OFS_SP, 32'hFEE0, RESP_OKAY);
    op(OP_INT_ACK, 16'h0100, 3'd2);
    chk("pc", 16'h0100, pc_o);
    chk("psw", 8'h00, psw_o);
    rd(OFS_SP, 32'hFEDD, RESP_OKAY);
    mem(16'hFEDF, 8'h80, RG_RAM);
    mem(16'hFEDE, 8'h12, RG_RAM);
    mem(16'hFEDD, 8'h36, RG_RAM);
    op(OP_INTERRUPT_RETURN_OP, 0, 0);
    chk("pc", 16'h1236, pc_o);
    chk("psw", 8'h80, psw_o);
    op(OP_FAR_CALL, 16'h1000, 3'd2);
    chk("err", 1, got_err);
    op(OP_FAR_CALL, 16'h0FFF, 3'd2);
    chk("pc", 16'h0FFF, pc_o);
    rd(OFS_SP, 32'hFEDE, RESP_OKAY);
    op(OP_RET, 0, 0);
    chk("pc", 16'h1238, pc_o);
endtask
// bank switch, alu flags, regions and bank area fetch
task automatic t_flags;
    op(OP_SEL_BANK, 16'h0002, 0);
    chk("psw", 8'hA0, psw_o);
    reg_i <= '{1'b1, 1'b0, 3'd1, 16'h005A};
    alu_i <= '{1'b1, 1'b1, 8'h05, 8'h05, 1'b0, 1'b0};
    @(posedge clk_i);
    reg_i.we <= 0;
    alu_i <= '{1'b1, 1'b0, 8'h0F, 8'h01, 1'b0, 1'b0};
    @(posedge clk_i);
    chk("zero", 1, psw_o[PSW_Z]);
    alu_i <= '{1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1};
    @(posedge clk_i);
    chk("zero", 0, psw_o[PSW_Z]);
    chk("half", 1, psw_o[PSW_AC]);
    alu_i <= '0;
    @(posedge clk_i);
    chk("carry", 1, psw_o[PSW_CY]);
    mem(16'hFEE9, 8'h5A, RG_BANK);
    mem(16'hFF10, 8'h00, RG_SFR);
    op(OP_BRANCH, 16'hFEE0, 0);
    chk("fault", 1, fetch_fault_o);
endtask
// data port writes, address regions and bank register views
task automatic t_data;
    dat_i <= '{1'b1, 1'b1, 16'hFC00, 8'hA5};
    @(posedge clk_i);
    dat_i <= '{1'b1, 1'b1, 16'hFEE8, 8'h3C};
    @(posedge clk_i);
    mem(16'hFC00, 8'hA5, RG_RAM);
    mem(16'hFBFF, 8'h00, RG_ROM);
    mem(16'h0085, 8'h00, RG_DBG_ID);
    mem(16'h108E, 8'h00, RG_DBG_ID);
    reg_i <= '{1'b0, 1'b0, 3'd0, 16'h0000};
    repeat (2) @(posedge clk_i);
    chk("reg", 16'h003C, reg_rdata_o);
    reg_i <= '{1'b1, 1'b1, 3'd1, 16'hBEEF};
    @(posedge clk_i);
    reg_i.we <= 0;
    repeat (2) @(posedge clk_i);
    chk("pair", 16'hBEEF, reg_rdata_o);
    mem(16'hFEEB, 8'hBE, RG_BANK);
endtask
// stacking of status word, break and call frames
task automatic t_stack;
    op(OP_ADVANCE, 16'h0000, 3'd3);
    chk("pc", 16'hFEE3, pc_o);
    op(OP_DI, 16'h0000, 3'd0);
    chk("psw", 8'h31, psw_o);
    op(OP_PUSH_PSW, 16'h0000, 3'd0);
    wr(OFS_PSW, 32'h02, RESP_OKAY);
    op(OP_POP_PSW, 16'h0000, 3'd0);
    chk("psw", 8'h31, psw_o);
    rd(OFS_SP, 32'hFEE0, RESP_OKAY);
    op(OP_BRK, 16'h0200, 3'd1);
    rd(OFS_SP, 32'hFEDD, RESP_OKAY);
    wr(OFS_PSW, 32'h02, RESP_OKAY);
    op(OP_BREAK_RETURN_OP, 16'h0000, 3'd0);
    chk("pc", 16'hFEE4, pc_o);
    chk("psw", 8'h31, psw_o);
    op(OP_CALL, 16'h0300, 3'd3);
    mem(16'hFEDE, 8'hE7, RG_RAM);
    op(OP_RET, 16'h0000, 3'd0);
    chk("pc", 16'hFEE7, pc_o);
endtask
// stack pointer outside ram is caught and cleared by a reload
task automatic t_fault;
    wr(OFS_SP, 32'h0000, RESP_OKAY);
    op(OP_PUSH_PSW, 16'h0000, 3'd0);
    chk("stack", 1, stack_fault_o);
    rd(OFS_STAT, 32'h6, RESP_OKAY);
    wr(OFS_SP, 32'hFEE0, RESP_OKAY);
    chk("stack", 0, stack_fault_o);
endtask
// run every scenario in turn, then judge
initial begin
    t_boot;
    t_irq;
    t_int_stack;
    t_flags;
    t_data;
    t_stack;
    t_fault;
    give_verdict;
end
// watchdog cuts a hang short
initial begin
    #200000;
    failures++;
    give_verdict;
end
endmodule
